// File: hw/xlat_consts.svh
`ifndef XLAT_CONSTS_SVH
`define XLAT_CONSTS_SVH

// register byte offsets on the apb side
`define REG_CTRL 8'h00
`define REG_VADDR 8'h04
`define REG_WDATA 8'h08
`define REG_CMD 8'h0c
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14
`define REG_PADDR 8'h18
`define REG_TAG 8'h1c

// control register fields
`define CTRL_GRANT 0
`define CTRL_DIAG 1
`define CTRL_PHYS 2
`define CTRL_MAINT 3
`define CTRL_RESET 4'h0

// command register fields
`define CMD_WRITE 0
`define CMD_READ 1
`define CMD_PERIPH 2

// status register fields
`define STAT_PERR 0
`define STAT_BUSY 1
`define STAT_ERRSUM 2

// entry layout: pfn, protection, modify, valid, odd byte, parity
`define ENT_W 23
`define ENT_PFN_HI 22
`define ENT_PFN_LO 8
`define ENT_PROT_HI 7
`define ENT_PROT_LO 4
`define ENT_MOD 3
`define ENT_VALID 2
`define ENT_ODD 1
`define ENT_PAR 0

// buffer geometry
`define TB_DEPTH 1024
`define TAG_DEPTH 128
`define TAG_W 16

`endif

// File: hw/xlat_pkg.sv
package xlat_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOOK = 3'h1,
      ST_NEXT = 3'h3,
      ST_PWR = 3'h4,
      ST_PRD = 3'h5
   } xlat_state_t;
endpackage

// File: hw/entry_parity.sv
`timescale 1ns/1ps
`default_nettype none
// even composite parity over one entry; the same logic serves store and check
module entry_parity (
   input wire logic [14:0] page_frame_number,
   input wire logic odd_byte,
   input wire logic valid,
   input wire logic [3:0] protection_bits,
   input wire logic modify,
   input wire logic parity_diag_force,
   output logic frame_parity_component,
   output logic protection_parity_component,
   output logic composite
);
   assign frame_parity_component = ^{page_frame_number, odd_byte, parity_diag_force};
   assign protection_parity_component = ^{protection_bits, modify};
   assign composite = frame_parity_component ^ valid ^ protection_parity_component;
endmodule
`default_nettype wire

// File: hw/entry_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// bidirectional entry shifter that moves no bits; bit positions are kept by the wiring
module entry_shifter #(
   parameter int W = 15
) (
   input wire logic en,
   input wire logic read_dir,
   input wire logic [W-1:0] bus_side,
   input wire logic [W-1:0] entry_side,
   output logic [W-1:0] to_entry,
   output logic [W-1:0] to_bus
);
   assign to_entry = (en && !read_dir) ? bus_side : '0;
   assign to_bus = (en && read_dir) ? entry_side : '0;
endmodule
`default_nettype wire

// File: hw/io_bus_tlb_translation.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "xlat_consts.svh"
// Function
// - two low address bits pick the byte and go to rotator control
// - address bits 8:2 give the longword offset within the page
// - address bits 17:9 index the buffer to fetch the frame number
// - grant low asserts idle; lookup state or peripheral command asserts source select; address register loads only while idle with the sequencer in idle
// - master sync moves the sequencer from idle into translation
// - counter loads bits 17:2, then steps one longword for two-cycle access
// - two-cycle write across a page: first longword goes before next check
// - source select routes counter 17:15 onto index lines 8:6
// - top index line is high for every peripheral translation
// - 1K entries of 23 bits: upper 512 peripheral, lowest 128 processor
// - store enabled unless direct physical; output only without write enable
// - entry holds frame, protection, modify, valid, odd byte and parity
// - every read checks composite parity; mismatch sets status, and error summary on peripheral lookups only
// - writes store the same composite parity; diagnostic input forces a component
// - odd-byte bit adds one to even word address via rotator control
// - write moves frame up eight: byte rotate only, the shifters keep bit positions
// - frame shifter maps bus 22:8 to entry 22:8; protection shifter bus 7:1 to entry 7:1
// - frame shifter uses enable-or-maint, protection plain enable; both follow direction
// - write enable opens the write path and blocks the output path
// - processor-space writes also store tag from address bits 30:15
// - buffer read rotates right one byte back to bus format, with no bit shift
module io_bus_tlb_translation (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [17:0] periph_addr,
   input wire logic master_sync,
   input wire logic two_cycle,
   output logic periph_idle,
   output logic [23:0] phys_addr,
   output logic [2:0] rot_ctrl,
   output logic xlat_done,
   output logic periph_error_summary
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] tb_index(input logic periph, input logic [8:0] hi);
      tb_index = periph ? {1'b1, hi} : {3'b000, hi[6:0]};
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= `REG_TAG);
   endfunction

   xlat_pkg::xlat_state_t state;
   logic [3:0] ctrl;
   logic [30:0] vaddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [2:0] cmd;
   logic perr;
   logic [17:0] addr_s1, addr_s2;
   logic [2:0] msync_sh;
   logic [1:0] two_sh;
   logic [17:0] latched_addr_bits;
   logic [17:2] cnt;
   logic second;
   logic [22:0] tb [0:`TB_DEPTH-1];
   logic [15:0] tag [0:`TAG_DEPTH-1];

   logic acc, wr_acc, msync_rise, addr_load_clock;
   logic xlat_source_select, xlat_write_enable, direct_physical_mode, store_en;
   logic entry_shift_enable, frame_shift_enable, entry_shift_read_dir;
   logic [2:0] special_function_bits;
   logic [9:0] xlat_index_lines;
   logic [22:0] rd_entry, wr_entry;
   logic [31:0] rot_bus, rd_bus;
   logic [14:0] fr_to_entry, fr_to_bus;
   logic [6:0] pr_to_entry, pr_to_bus;
   logic rd_comp, wr_comp, rd_mismatch;

   assign acc = psel && penable && pready;
   assign wr_acc = acc && pwrite;
   assign direct_physical_mode = ctrl[`CTRL_PHYS];
   ////////////////////////////////////////////////////////////////////////////
   // pin inputs pass two flops; msync edge is taken between flops two and three
   always_ff @(posedge clk) begin
      addr_s1 <= periph_addr;
      addr_s2 <= addr_s1;
      two_sh <= {two_sh[0], two_cycle};
      if (srst) begin
         msync_sh <= 3'h0;
      end else begin
         msync_sh <= {msync_sh[1:0], master_sync};
      end
   end
   assign msync_rise = msync_sh[1] && !msync_sh[2];

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state so every output is a flop
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !is_mapped(paddr);
         if (psel && penable && !pready && !pwrite) begin
            case (paddr)
               `REG_CTRL: prdata <= {28'h0, ctrl};
               `REG_VADDR: prdata <= {1'b0, vaddr};
               `REG_WDATA: prdata <= wdata;
               `REG_CMD: prdata <= {29'h0, cmd};
               `REG_STATUS: prdata <= {29'h0, periph_error_summary, state != xlat_pkg::ST_IDLE, perr};
               `REG_RDATA: prdata <= rdata;
               `REG_PADDR: prdata <= {8'h0, phys_addr};
               `REG_TAG: prdata <= {16'h0, tag[vaddr[15:9]]};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= `CTRL_RESET;
         vaddr <= 31'h0;
         wdata <= 32'h0;
      end else if (wr_acc) begin
         if (paddr == `REG_CTRL) ctrl <= pwdata[3:0];
         if (paddr == `REG_VADDR) vaddr <= pwdata[30:0];
         if (paddr == `REG_WDATA) wdata <= pwdata;
      end
   end

   // commands wait in cmd until the sequencer is idle
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd <= 3'h0;
      end else if (wr_acc && paddr == `REG_CMD && cmd[1:0] == 2'h0) begin
         cmd <= pwdata[2:0];
      end else if (state == xlat_pkg::ST_PWR || state == xlat_pkg::ST_PRD) begin
         cmd <= 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= xlat_pkg::ST_IDLE;
      end else begin
         case (state)
            xlat_pkg::ST_IDLE: begin
               if (cmd[`CMD_WRITE]) state <= xlat_pkg::ST_PWR;
               else if (cmd[`CMD_READ]) state <= xlat_pkg::ST_PRD;
               else if (msync_rise && !ctrl[`CTRL_GRANT]) state <= xlat_pkg::ST_LOOK;
            end
            // first longword is sent before the next page is looked at
            xlat_pkg::ST_LOOK: state <= (two_sh[1] && !second) ? xlat_pkg::ST_NEXT : xlat_pkg::ST_IDLE;
            xlat_pkg::ST_NEXT: state <= xlat_pkg::ST_LOOK;
            default: state <= xlat_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) second <= 1'b0;
      else if (state == xlat_pkg::ST_NEXT) second <= 1'b1;
      else if (state == xlat_pkg::ST_IDLE) second <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // address register and longword counter
   assign addr_load_clock = periph_idle && state == xlat_pkg::ST_IDLE;
   always_ff @(posedge clk) begin
      if (srst) begin
         periph_idle <= 1'b0;
         latched_addr_bits <= 18'h0;
         cnt <= 16'h0;
      end else begin
         periph_idle <= !ctrl[`CTRL_GRANT];
         if (addr_load_clock) latched_addr_bits <= addr_s2;
         if (state == xlat_pkg::ST_IDLE && msync_rise) cnt <= latched_addr_bits[17:2];
         else if (state == xlat_pkg::ST_NEXT) cnt <= cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer indexing and data paths
   assign special_function_bits = {state == xlat_pkg::ST_PWR, state == xlat_pkg::ST_PRD, state == xlat_pkg::ST_LOOK};
   assign xlat_source_select = special_function_bits[0] || cmd[`CMD_PERIPH];
   // peripheral lookups force the top index line high, keeping them in the upper half
   assign xlat_index_lines = special_function_bits[0] ? tb_index(1'b1, cnt[17:9]) :
                             tb_index(xlat_source_select, vaddr[17:9]);
   assign xlat_write_enable = state == xlat_pkg::ST_PWR;
   assign store_en = !direct_physical_mode;
   assign rd_entry = xlat_write_enable ? 23'h0 : tb[xlat_index_lines];
   assign entry_shift_enable = special_function_bits[2] || special_function_bits[1];
   assign frame_shift_enable = entry_shift_enable || ctrl[`CTRL_MAINT];
   assign entry_shift_read_dir = special_function_bits[1];
   assign rot_bus = {wdata[23:0], wdata[31:24]};

   entry_shifter #(.W(15)) u_frame (
      .en(frame_shift_enable),
      .read_dir(entry_shift_read_dir),
      .bus_side(rot_bus[22:8]),
      .entry_side(rd_entry[`ENT_PFN_HI:`ENT_PFN_LO]),
      .to_entry(fr_to_entry),
      .to_bus(fr_to_bus)
   );

   entry_shifter #(.W(7)) u_prot (
      .en(entry_shift_enable),
      .read_dir(entry_shift_read_dir),
      .bus_side(rot_bus[7:1]),
      .entry_side(rd_entry[`ENT_PROT_HI:`ENT_ODD]),
      .to_entry(pr_to_entry),
      .to_bus(pr_to_bus)
   );

   // diag forces the frame component on both paths, so flip it between write and read to inject
   entry_parity u_wpar (
      .page_frame_number(fr_to_entry),
      .odd_byte(pr_to_entry[0]),
      .valid(pr_to_entry[1]),
      .protection_bits(pr_to_entry[6:3]),
      .modify(pr_to_entry[2]),
      .parity_diag_force(ctrl[`CTRL_DIAG]),
      .frame_parity_component(),
      .protection_parity_component(),
      .composite(wr_comp)
   );

   entry_parity u_rpar (
      .page_frame_number(rd_entry[`ENT_PFN_HI:`ENT_PFN_LO]),
      .odd_byte(rd_entry[`ENT_ODD]),
      .valid(rd_entry[`ENT_VALID]),
      .protection_bits(rd_entry[`ENT_PROT_HI:`ENT_PROT_LO]),
      .modify(rd_entry[`ENT_MOD]),
      .parity_diag_force(ctrl[`CTRL_DIAG]),
      .frame_parity_component(),
      .protection_parity_component(),
      .composite(rd_comp)
   );

   assign wr_entry = {fr_to_entry, pr_to_entry, wr_comp};
   assign rd_mismatch = rd_comp != rd_entry[`ENT_PAR];
   assign rd_bus = {9'h0, fr_to_bus, pr_to_bus, 1'b0};

   // storage is not reset; software writes entries before use
   always_ff @(posedge clk) begin
      if (xlat_write_enable && store_en) begin
         tb[xlat_index_lines] <= wr_entry;
         if (!xlat_index_lines[9]) tag[xlat_index_lines[6:0]] <= vaddr[30:15];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) rdata <= 32'h0;
      else if (state == xlat_pkg::ST_PRD) rdata <= {rd_bus[7:0], rd_bus[31:8]};
   end

   ////////////////////////////////////////////////////////////////////////////
   // translation result and error reporting
   always_ff @(posedge clk) begin
      if (srst) begin
         phys_addr <= 24'h0;
         rot_ctrl <= 3'h0;
         xlat_done <= 1'b0;
      end else begin
         xlat_done <= state == xlat_pkg::ST_LOOK;
         if (state == xlat_pkg::ST_LOOK) begin
            phys_addr <= {rd_entry[`ENT_PFN_HI:`ENT_PFN_LO], cnt[8:2], latched_addr_bits[1:0]};
            rot_ctrl <= {rd_entry[`ENT_ODD], latched_addr_bits[1:0]};
         end
      end
   end

   // status flag: a new error wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         perr <= 1'b0;
         periph_error_summary <= 1'b0;
      end else begin
         if ((state == xlat_pkg::ST_LOOK || state == xlat_pkg::ST_PRD) && rd_mismatch) perr <= 1'b1;
         else if (wr_acc && paddr == `REG_STATUS && pwdata[`STAT_PERR]) perr <= 1'b0;
         if (state == xlat_pkg::ST_LOOK) periph_error_summary <= rd_mismatch;
         else if (state == xlat_pkg::ST_IDLE && msync_rise) periph_error_summary <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_idle_follows_grant: assert property (!$past(srst) |-> periph_idle == !$past(ctrl[`CTRL_GRANT]))
      else $error("idle does not follow grant");
   a_msync_starts: assert property (state == xlat_pkg::ST_IDLE && !cmd[1] && !cmd[0] && msync_rise
      && !ctrl[0] |=> state == xlat_pkg::ST_LOOK)
      else $error("master sync did not start translation");
   a_counter_step: assert property (state == xlat_pkg::ST_NEXT |=> cnt == $past(cnt) + 16'h0001)
      else $error("counter did not step one longword");
   a_first_word_out: assert property (state == xlat_pkg::ST_NEXT |-> xlat_done ##2 xlat_done)
      else $error("two-cycle words not both delivered");
   a_index_upper_half: assert property (state == xlat_pkg::ST_LOOK |-> xlat_index_lines == {1'b1, cnt[17:9]})
      else $error("peripheral index wrong");
   a_result_addr: assert property (state == xlat_pkg::ST_LOOK |=> xlat_done
      && phys_addr[8:2] == $past(cnt[8:2]) && phys_addr[23:9] == $past(rd_entry[22:8])
      && rot_ctrl[2] == $past(rd_entry[1]))
      else $error("translated address wrong");
   a_parity_error: assert property (state == xlat_pkg::ST_LOOK && rd_mismatch |=> periph_error_summary && perr)
      else $error("parity error not reported");
   a_write_parity: assert property (xlat_write_enable && store_en
      |=> tb[$past(xlat_index_lines)] == $past(wr_entry) && ^$past(wr_entry) == $past(ctrl[1]))
      else $error("entry stored with wrong parity");
   a_write_blocks_out: assert property (xlat_write_enable |-> rd_entry == 23'h0 && fr_to_bus == 15'h0)
      else $error("output path open during write");
   a_read_format: assert property (state == xlat_pkg::ST_PRD
      |=> rdata[14:0] == $past(rd_entry[22:8]) && rdata[31:25] == $past(rd_entry[7:1]))
      else $error("read entry not in bus format");
   a_byte_select: assert property (state == xlat_pkg::ST_LOOK
      |=> rot_ctrl[1:0] == $past(latched_addr_bits[1:0]) && phys_addr[1:0] == $past(latched_addr_bits[1:0]))
      else $error("byte select bits not passed on");
   // stored-entry checks need the entry written once; unwritten storage reads unknown
   a_phys_shuts_store: assert property (xlat_write_enable && direct_physical_mode
      |=> tb[$past(xlat_index_lines)] == $past(tb[xlat_index_lines]))
      else $error("buffer written in direct physical mode");
   a_tag_store: assert property (xlat_write_enable && store_en && !xlat_index_lines[9]
      |=> tag[$past(xlat_index_lines[6:0])] == $past(vaddr[30:15]))
      else $error("tag not stored with processor entry");
   a_maint_frame: assert property (ctrl[`CTRL_MAINT] && !entry_shift_read_dir
      |-> fr_to_entry == rot_bus[22:8])
      else $error("frame shifter not enabled by maintenance");

   c_two_cycle: cover property (state == xlat_pkg::ST_NEXT ##1 state == xlat_pkg::ST_LOOK);
   c_parity_err: cover property (state == xlat_pkg::ST_LOOK && rd_mismatch);
   c_proc_write: cover property (xlat_write_enable && store_en);
   c_proc_read: cover property (state == xlat_pkg::ST_PRD);
   c_maint: cover property (ctrl[`CTRL_MAINT] && frame_shift_enable && !entry_shift_enable);
endmodule
`default_nettype wire

// File: tb/periph_master.sv
`timescale 1ns/1ps
`default_nettype none
// peripheral-bus master: presents an address, raises master sync, records each translated longword
module periph_master (
   input wire logic clk,
   input wire logic xlat_done,
   input wire logic [23:0] phys_addr,
   input wire logic [2:0] rot_ctrl,
   output logic [17:0] periph_addr,
   output logic master_sync,
   output logic two_cycle
);
   logic [26:0] seen[$];
   initial begin
      periph_addr = 18'h3ffff;
      master_sync = 1'b0;
      two_cycle = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // done is a one-cycle pulse, so it is caught at the edge it stands for
   always @(posedge clk) begin
      if (xlat_done === 1'b1) begin
         seen.push_back({rot_ctrl, phys_addr});
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // entered just after a rising edge; want is how many longwords should come back
   task automatic xfer(input logic [17:0] a, input logic two, input int want);
      int n;
      begin
         n = 0;
         seen.delete();
         periph_addr <= a;
         two_cycle <= two;
         // address goes through its synchroniser and the address register before master sync rises
         repeat (3) @(posedge clk);
         master_sync <= 1'b1;
         while (n < 20 && (want == 0 || seen.size() < want)) begin
            @(posedge clk);
            n++;
         end
         // a few more edges so a stray extra pulse is seen too
         repeat (4) @(posedge clk);
         master_sync <= 1'b0;
         two_cycle <= 1'b0;
         // released lines do not keep the old address
         periph_addr <= ~a;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// File: tb/io_bus_tlb_translation_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "xlat_consts.svh"
module io_bus_tlb_translation_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [17:0] periph_addr;
   logic master_sync;
   logic two_cycle;
   logic periph_idle;
   logic [23:0] phys_addr;
   logic [2:0] rot_ctrl;
   logic xlat_done;
   logic periph_error_summary;
   int err_total = 0;
   int comparisons = 0;
   logic [31:0] q;
   logic e;

   always #50 clk = ~clk;

   io_bus_tlb_translation uut (
      .clk(clk),
      .srst(srst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .periph_addr(periph_addr),
      .master_sync(master_sync),
      .two_cycle(two_cycle),
      .periph_idle(periph_idle),
      .phys_addr(phys_addr),
      .rot_ctrl(rot_ctrl),
      .xlat_done(xlat_done),
      .periph_error_summary(periph_error_summary)
   );

   periph_master pm (
      .clk(clk),
      .xlat_done(xlat_done),
      .phys_addr(phys_addr),
      .rot_ctrl(rot_ctrl),
      .periph_addr(periph_addr),
      .master_sync(master_sync),
      .two_cycle(two_cycle)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task chk_pin(input logic [26:0] got, input logic [26:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t pin got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; entered just after a rising edge, leaves one idle edge behind
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         do begin
            @(posedge clk);
         end while (pready !== 1'b1);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask

   // entry command, then poll busy; the watchdog guards against a hang
   task cmd(input logic [31:0] va, input logic [31:0] d, input logic [2:0] c);
      begin
         apb(1'b1, `REG_VADDR, va);
         apb(1'b1, `REG_WDATA, d);
         apb(1'b1, `REG_CMD, {29'h0, c});
         do begin
            apb(1'b0, `REG_STATUS, 32'h0);
         end while (q[`STAT_BUSY] !== 1'b0);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      results();
   end

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk_pin({26'h0, periph_idle}, 27'h1);
      apb(1'b0, `REG_CTRL, 32'h0);
      chk_reg(q, 32'h0);
      // two neighbouring peripheral pages, and a processor entry with the same low index bits
      cmd(32'h0000_a400, 32'hae00_4d2b, 3'h5);
      cmd(32'h0000_a600, 32'h0400_0123, 3'h5);
      cmd(32'h1234_a400, 32'h0000_7777, 3'h1);
      apb(1'b0, `REG_TAG, 32'h0);
      chk_reg(q, 32'h0000_2469);
      cmd(32'h0000_a400, 32'h0, 3'h6);
      apb(1'b0, `REG_RDATA, 32'h0);
      chk_reg(q, 32'hae00_4d2b);
      cmd(32'h1234_a400, 32'h0, 3'h2);
      apb(1'b0, `REG_RDATA, 32'h0);
      chk_reg(q, 32'h0000_7777);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk_reg(q, 32'h0);
      // two-cycle access from the last longword of a page into the next page
      pm.xfer({9'h052, 7'h7f, 2'b10}, 1'b1, 2);
      chk_pin(27'(pm.seen.size()), 27'd2);
      chk_pin(pm.seen[0], {3'b110, 15'h4d2b, 7'h7f, 2'b10});
      chk_pin(pm.seen[1], {3'b010, 15'h0123, 7'h00, 2'b10});
      chk_pin({26'h0, periph_error_summary}, 27'h0);
      pm.xfer({9'h053, 7'h05, 2'b01}, 1'b0, 1);
      chk_pin(pm.seen[0], {3'b001, 15'h0123, 7'h05, 2'b01});
      // forcing a component at lookup time breaks the stored parity
      apb(1'b1, `REG_CTRL, 32'h2);
      pm.xfer({9'h053, 7'h05, 2'b01}, 1'b0, 1);
      chk_pin({26'h0, periph_error_summary}, 27'h1);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk_reg(q, 32'h5);
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b1, `REG_STATUS, 32'h1);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk_reg(q, 32'h4);
      pm.xfer({9'h053, 7'h05, 2'b01}, 1'b0, 1);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk_reg(q, 32'h0);
      // direct physical mode keeps the buffer shut against writes
      apb(1'b1, `REG_CTRL, 32'h4);
      cmd(32'h0000_a600, 32'h0000_1111, 3'h5);
      apb(1'b1, `REG_CTRL, 32'h0);
      cmd(32'h0000_a600, 32'h0, 3'h6);
      apb(1'b0, `REG_RDATA, 32'h0);
      chk_reg(q, 32'h0400_0123);
      // maintenance enable bit is written and read back from the control register
      apb(1'b1, `REG_CTRL, 32'h8);
      apb(1'b0, `REG_CTRL, 32'h0);
      chk_reg(q, 32'h8);
      // processor grant: bus not idle, master sync is lost
      apb(1'b1, `REG_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk_pin({26'h0, periph_idle}, 27'h0);
      pm.xfer({9'h052, 7'h00, 2'b00}, 1'b0, 0);
      chk_pin(27'(pm.seen.size()), 27'd0);
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk_reg({31'h0, e}, 32'h1);
      chk_reg(q, 32'h0);
      results();
   end
endmodule
`default_nettype wire
